// ---- rtl/sfc_device.sv ----
`timescale 1ns/10ps
// Functional notes
// - host runs one init cycle after power-on
// - init: one to eight falls, cs rises
// - marker 3fc0 follows valid init
// - init may start/end on frame sync
// - sampling spans 20 clocks from fifth
// - conversion starts after 24th falling edge
// - cs release never aborts conversion
// - conversion done within 2.67 us
// - conversion takes 20 oscillator clocks
// - host waits for conversion before next frame
// - cut conversion gives marker next frame
// - output is previous frame's sample
// - 16 bits msb first, result in 15:2
// - tristate at 17th rise or cs rise
// - cs falling presents msb, cs-only mode
// - data changes on rising serial edge
// - fs rising presents msb, fs-only mode
// - both mode: msb on fs rise, sample on fall
// - control edges accepted at any clock level
// - cs high half a period between frames
// - cs held low for 24 falling edges
// - results unipolar straight binary
// - power down after conversion, wake on frame
module sfc_device
    import sfc_pkg::*;
#(
    parameter sfc_mode_t MODE = SFC_MODE_CS
)(
    input  wire logic                   core_clk_i,
    input  wire logic                   rst_n_i,
    sfc_link_if.device                  link,
    input  wire logic [RESULT_BITS-1:0] analog_code_i,
    input  wire logic                   analog_valid_i,
    output logic                        analog_ready_o,
    output logic                        powered_down_o,
    output logic                        converting_o,
    output logic                        sampling_o
);
    // link pins come from another domain: two flops first
    logic [1:0] sclk_sync_reg;
    logic [1:0] cs_sync_reg;
    logic [1:0] fs_sync_reg;
    logic       sclk_d_reg;
    logic       cs_d_reg;
    logic       fs_d_reg;

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sclk_sync_reg <= 2'h0;
            cs_sync_reg   <= 2'h3;
            fs_sync_reg   <= 2'h3;
            sclk_d_reg    <= 1'b0;
            cs_d_reg      <= 1'b1;
            fs_d_reg      <= 1'b1;
        end
        else
        begin
            sclk_sync_reg <= {sclk_sync_reg[0], link.sclk};
            cs_sync_reg   <= {cs_sync_reg[0], link.cs_n};
            fs_sync_reg   <= {fs_sync_reg[0], link.frame_sync_in};
            sclk_d_reg    <= sclk_sync_reg[1];
            cs_d_reg      <= cs_sync_reg[1];
            fs_d_reg      <= fs_sync_reg[1];
        end
    end

    logic sclk_s, cs_s, fs_s;
    logic sclk_rise, sclk_fall, cs_fall, cs_rise, fs_rise, fs_fall;
    assign sclk_s    = sclk_sync_reg[1];
    assign cs_s      = cs_sync_reg[1];
    assign fs_s      = fs_sync_reg[1];
    assign sclk_rise = sclk_s & ~sclk_d_reg;
    assign sclk_fall = ~sclk_s & sclk_d_reg;
    assign cs_fall   = ~cs_s & cs_d_reg;
    assign cs_rise   = cs_s & ~cs_d_reg;
    assign fs_rise   = fs_s & ~fs_d_reg;
    assign fs_fall   = ~fs_s & fs_d_reg;

    // frame boundaries per framing mode; control edges are sampled by the
    // core clock, so the serial clock level at that moment does not matter
    logic frame_start, present_msb, count_start, frame_end, init_start;
    always_comb
    begin
        frame_start = 1'b0;
        present_msb = 1'b0;
        count_start = 1'b0;
        frame_end   = 1'b0;
        init_start  = 1'b0;
        case (MODE)
            SFC_MODE_CS:
            begin
                frame_start = cs_fall & fs_s;
                present_msb = frame_start;
                count_start = frame_start;
                frame_end   = cs_rise;
            end
            SFC_MODE_FS:
            begin
                frame_start = fs_rise & ~cs_s;
                present_msb = frame_start;
                count_start = fs_fall & ~cs_s;
                frame_end   = cs_rise;
                init_start  = fs_fall & ~cs_s;
            end
            default:
            begin
                frame_start = (fs_rise & ~cs_s) | cs_fall;
                present_msb = fs_rise & ~cs_s;
                count_start = fs_fall & ~cs_s;
                frame_end   = cs_rise;
                init_start  = fs_fall & ~cs_s;
            end
        endcase
    end

    // frame counters of serial clock edges
    logic       active_reg;
    logic [5:0] fall_cnt_reg;
    logic [5:0] rise_cnt_reg;
    logic       counting_reg;
    logic       init_edge_reg;  // a window may end by fs rising
    logic       fs_end;
    assign fs_end = init_edge_reg & fs_rise;

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            active_reg    <= 1'b0;
            counting_reg  <= 1'b0;
            fall_cnt_reg  <= 6'h00;
            rise_cnt_reg  <= 6'h00;
            init_edge_reg <= 1'b0;
        end
        else if (count_start | (frame_start & MODE == SFC_MODE_CS))
        begin
            active_reg    <= 1'b1;
            counting_reg  <= 1'b1;
            fall_cnt_reg  <= 6'h00;
            rise_cnt_reg  <= 6'h00;
            init_edge_reg <= init_start;
        end
        else if (frame_end | fs_end)
        begin
            active_reg    <= 1'b0;
            counting_reg  <= 1'b0;
            init_edge_reg <= 1'b0;
        end
        else if (counting_reg)
        begin
            if (sclk_fall && fall_cnt_reg != 6'h3f)
                fall_cnt_reg <= fall_cnt_reg + 6'h01;
            if (sclk_rise && rise_cnt_reg != 6'h3f)
                rise_cnt_reg <= rise_cnt_reg + 6'h01;
            if (sclk_fall && fall_cnt_reg == 6'(CONV_START_EDGE - 1))
                counting_reg <= 1'b0;
        end
    end

    // a short framed window counts as an init cycle
    logic init_hit;
    assign init_hit = (frame_end | fs_end) & active_reg &
                      fall_cnt_reg >= 6'(INIT_MIN_EDGES) &
                      fall_cnt_reg <= 6'(INIT_MAX_EDGES);

    // sampling window: fifth clock through the 24th
    assign sampling_o = counting_reg &
                        fall_cnt_reg >= 6'(SAMPLE_START - 1) &
                        fall_cnt_reg < 6'(SAMPLE_START - 1 + SAMPLE_LEN);
    logic conv_go;
    assign conv_go = counting_reg & sclk_fall &
                     fall_cnt_reg == 6'(CONV_START_EDGE - 1);

    // conversion on the internal oscillator, unaffected by cs release
    logic [7:0]             conv_cnt_reg;
    logic                   conv_reg;
    logic [RESULT_BITS-1:0] sample_reg;
    logic [FRAME_BITS-1:0]  next_word_reg;
    logic                   pd_reg;

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            conv_reg      <= 1'b0;
            conv_cnt_reg  <= 8'h00;
            sample_reg    <= RESULT_RESET;
            next_word_reg <= MARKER_WORD;
            pd_reg        <= 1'b1;
        end
        else
        begin
            if (frame_start)
                pd_reg <= 1'b0;
            if (init_hit)
                next_word_reg <= MARKER_WORD;
            if (frame_start & conv_reg)
            begin
                conv_reg      <= 1'b0;
                next_word_reg <= MARKER_WORD;
            end
            else if (conv_go)
            begin
                conv_reg     <= 1'b1;
                conv_cnt_reg <= 8'h00;
                sample_reg   <= analog_code_i;
            end
            else if (conv_reg)
            begin
                conv_cnt_reg <= conv_cnt_reg + 8'h01;
                if (conv_cnt_reg == 8'(CONV_CYCLES - 1))
                begin
                    conv_reg      <= 1'b0;
                    pd_reg        <= 1'b1;
                    next_word_reg <= {sample_reg,
                        {RESULT_LSB_POS{1'b0}}};
                end
            end
        end
    end
    assign converting_o   = conv_reg;
    assign powered_down_o = pd_reg;
    assign analog_ready_o = conv_go;

    // output shifter: msb presented on present_msb (fs rise only in both mode), shifts on rises
    logic [FRAME_BITS-1:0] shift_reg;
    logic                  oe_reg;
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            shift_reg <= 16'h0000;
            oe_reg    <= 1'b0;
        end
        else if (present_msb)
        begin
            shift_reg <= next_word_reg;
            oe_reg    <= 1'b1;
        end
        else if (cs_rise | (~active_reg & cs_s))
            oe_reg <= 1'b0;
        else if (oe_reg & sclk_rise)
        begin
            if (rise_cnt_reg == 6'(TRISTATE_RISE - 1))
                oe_reg <= 1'b0;
            // the msb must still stand at the first fall, so rise one holds
            else if (rise_cnt_reg != 6'h00)
                shift_reg <= {shift_reg[FRAME_BITS-2:0], 1'b0};
        end
    end
    assign link.serial_out    = shift_reg[FRAME_BITS-1];
    assign link.serial_out_oe = oe_reg;
endmodule : sfc_device

// ---- rtl/sfc_pkg.sv ----
package sfc_pkg;
    // frame geometry
    localparam int FRAME_BITS      = 16;
    localparam int RESULT_BITS     = 14;
    localparam int RESULT_LSB_POS  = 2;
    localparam int INIT_MIN_EDGES  = 1;
    localparam int INIT_MAX_EDGES  = 8;
    localparam int SAMPLE_START    = 5;
    localparam int SAMPLE_LEN      = 20;
    localparam int CONV_START_EDGE = 24;
    localparam int TRISTATE_RISE   = 17;
    localparam int CONV_OSC_CLKS   = 20;
    localparam logic [15:0] MARKER_WORD  = 16'h3fc0;
    localparam logic [13:0] RESULT_RESET = 14'h0000;
    // conversion time and internal oscillator
    localparam real CONV_MAX_US    = 2.67;
    localparam real OSC_MIN_MHZ    = 7.5;
    localparam real OSC_MAX_MHZ    = 12.0;
    localparam real CORE_MHZ       = 50.0;
    localparam int  OSC_DIV        = 5;  // 10 MHz, inside the allowed range
    localparam int  CONV_CYCLES    = CONV_OSC_CLKS * OSC_DIV;
    localparam int  CONV_MAX_CYC   = int'($floor(CONV_MAX_US * CORE_MHZ));
    // host serial clock divider: 50 MHz / (2*4) = 6.25 MHz
    localparam int  SCLK_HALF      = 4;
    localparam int  HOST_EDGES     = 24;
    localparam int  CS_HIGH_CYC    = 8;  // at least half a serial period

    typedef enum logic [1:0] {
        SFC_MODE_CS   = 2'b00,
        SFC_MODE_FS   = 2'b01,
        SFC_MODE_BOTH = 2'b10
    } sfc_mode_t;
endpackage : sfc_pkg

// ---- rtl/sfc_link_if.sv ----
`timescale 1ns/10ps
interface sfc_link_if;
    logic sclk;
    logic cs_n;
    logic frame_sync_in;
    logic serial_out;
    logic serial_out_oe;

    modport device (
        input  sclk,
        input  cs_n,
        input  frame_sync_in,
        output serial_out,
        output serial_out_oe
    );
    modport host (
        output sclk,
        output cs_n,
        output frame_sync_in,
        input  serial_out,
        input  serial_out_oe
    );
endinterface : sfc_link_if

// ---- rtl/sfc_host.sv ----
`timescale 1ns/10ps
module sfc_host
    import sfc_pkg::*;
#(
    parameter sfc_mode_t MODE = SFC_MODE_CS
)(
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_n_i,
    sfc_link_if.host                   link,
    input  wire logic                  init_req_i,
    input  wire logic                  frame_req_i,
    output logic                       busy_o,
    output logic [FRAME_BITS-1:0]      word_o,
    output logic                       word_valid_o,
    input  wire logic                  word_ready_i
);
    typedef enum logic [2:0] {
        SFC_IDLE = 3'b000,
        SFC_LEAD = 3'b001,
        SFC_RUN  = 3'b010,
        SFC_GAP  = 3'b011,
        SFC_WAIT = 3'b100
    } sfc_hstate_t;

    sfc_hstate_t state_reg;
    logic [3:0]  div_reg;
    logic        sclk_reg;
    logic        cs_reg;
    logic        fs_reg;
    logic [5:0]  edge_reg;
    logic [5:0]  goal_reg;
    logic [7:0]  wait_reg;
    logic [FRAME_BITS-1:0] rx_reg;
    logic        rx_done;
    logic        buf_ready;

    // serial data sampled after two flops
    logic [1:0] sdo_sync_reg;
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            sdo_sync_reg <= 2'h0;
        else
            sdo_sync_reg <= {sdo_sync_reg[0], link.serial_out};
    end

    logic tick;
    assign tick = div_reg == 4'(SCLK_HALF - 1);

    // frame sequencer; a new frame waits for buffer room, so no word drops
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= SFC_IDLE;
            div_reg   <= 4'h0;
            sclk_reg  <= 1'b0;
            cs_reg    <= 1'b1;
            fs_reg    <= 1'b1;
            edge_reg  <= 6'h00;
            goal_reg  <= 6'h00;
            wait_reg  <= 8'h00;
            rx_reg    <= 16'h0000;
        end
        else
        begin
            div_reg <= tick ? 4'h0 : div_reg + 4'h1;
            case (state_reg)
                SFC_IDLE:
                    if (tick & (init_req_i | (frame_req_i & buf_ready)))
                    begin
                        goal_reg  <= init_req_i ? 6'(INIT_MAX_EDGES)
                                                : 6'(HOST_EDGES);
                        edge_reg  <= 6'h00;
                        cs_reg    <= MODE == SFC_MODE_FS;
                        fs_reg    <= MODE != SFC_MODE_CS ? 1'b1 : 1'b1;
                        state_reg <= SFC_LEAD;
                    end
                SFC_LEAD:
                    if (tick)
                    begin
                        cs_reg    <= 1'b0;
                        fs_reg    <= MODE == SFC_MODE_CS;
                        state_reg <= SFC_RUN;
                    end
                SFC_RUN:
                    if (tick)
                    begin
                        sclk_reg <= ~sclk_reg;
                        if (sclk_reg)
                        begin
                            edge_reg <= edge_reg + 6'h01;
                            if (edge_reg == goal_reg - 6'h01)
                                state_reg <= SFC_GAP;
                        end
                        // the bit valid at fall k is taken just before rise
                        // k+1, once the sync flops have caught up with it
                        else if (edge_reg != 6'h00 &&
                                 edge_reg <= 6'(FRAME_BITS))
                            rx_reg <= {rx_reg[FRAME_BITS-2:0],
                                       sdo_sync_reg[1]};
                    end
                SFC_GAP:
                    if (tick)
                    begin
                        cs_reg    <= 1'b1;
                        fs_reg    <= 1'b1;
                        wait_reg  <= 8'h00;
                        state_reg <= SFC_WAIT;
                    end
                default:
                begin
                    wait_reg <= wait_reg + 8'h01;
                    if (wait_reg == 8'(CONV_MAX_CYC + CS_HIGH_CYC))
                        state_reg <= SFC_IDLE;
                end
            endcase
        end
    end
    assign link.sclk          = sclk_reg;
    assign link.cs_n          = cs_reg;
    assign link.frame_sync_in = fs_reg;
    assign busy_o             = state_reg != SFC_IDLE;
    assign rx_done = state_reg == SFC_GAP & tick & goal_reg == 6'(HOST_EDGES);

    // two-entry buffer between frame capture and the user
    logic [FRAME_BITS-1:0] buf_mem [2];
    logic                  wr_ptr_reg, rd_ptr_reg;
    logic [1:0]            cnt_reg;
    assign buf_ready = cnt_reg != 2'h2;
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            cnt_reg    <= 2'h0;
        end
        else
        begin
            if (rx_done & buf_ready)
            begin
                buf_mem[wr_ptr_reg] <= rx_reg;
                wr_ptr_reg          <= ~wr_ptr_reg;
            end
            if (word_valid_o & word_ready_i)
                rd_ptr_reg <= ~rd_ptr_reg;
            cnt_reg <= cnt_reg + 2'(rx_done & buf_ready)
                               - 2'(word_valid_o & word_ready_i);
        end
    end
    assign word_valid_o = cnt_reg != 2'h0;
    assign word_o       = buf_mem[rd_ptr_reg];
endmodule : sfc_host

// ---- testbench/sfc_link_sva.sv ----
`timescale 1ns/10ps
module sfc_link_sva
    import sfc_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic frame_sync_in,
    input  wire logic serial_out,
    input  wire logic serial_out_oe
);
    logic       sclk_reg;
    logic [5:0] fall_cnt_reg;
    logic [5:0] rise_cnt_reg;
    logic [3:0] rise_age_reg;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // serial clock edges per selected frame, cleared while deselected
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sclk_reg     <= 1'b0;
            fall_cnt_reg <= 6'h00;
            rise_cnt_reg <= 6'h00;
        end
        else
        begin
            sclk_reg <= sclk;
            if (cs_n)
            begin
                fall_cnt_reg <= 6'h00;
                rise_cnt_reg <= 6'h00;
            end
            else
            begin
                fall_cnt_reg <= fall_cnt_reg + {5'h00, sclk_reg & ~sclk};
                rise_cnt_reg <= rise_cnt_reg + {5'h00, sclk & ~sclk_reg};
            end
        end
    end

    // age since the last rise, saturating so it never wraps back to legal
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rise_age_reg <= 4'hf;
        else if (sclk & ~sclk_reg)
            rise_age_reg <= 4'h0;
        else if (rise_age_reg != 4'hf)
            rise_age_reg <= rise_age_reg + 4'h1;
    end

    // a fall seen in the same sample as the release still counts
    a_frame_fall_count: assert property ($rose(cs_n) |->
        (fall_cnt_reg + {5'h00, sclk_reg & ~sclk}) inside {6'h08, 6'h18})
        else $error("frame ended after a wrong number of falls");
    a_tristate_after_17th: assert property (
        $rose(sclk) && rise_cnt_reg == 6'h10 |-> ##[1:6] !serial_out_oe)
        else $error("output still driven after 17th rise");
    a_release_tristate: assert property (
        $rose(cs_n) |-> ##[1:6] !serial_out_oe)
        else $error("output still driven after release");
    a_idle_output_off: assert property (
        cs_n [*6] |-> !serial_out_oe)
        else $error("output driven while idle");
    a_msb_on_select: assert property (
        $fell(cs_n) |-> ##[1:6] serial_out_oe)
        else $error("msb not presented after select");
    a_data_on_rise: assert property (
        serial_out_oe && $past(serial_out_oe) && $changed(serial_out)
        |-> rise_age_reg <= 4'h6)
        else $error("data changed away from a rising edge");
    a_clock_idle_low: assert property (cs_n |-> !sclk)
        else $error("serial clock not idle low");
    a_select_gap: assert property ($rose(cs_n) |-> cs_n [*4])
        else $error("select high time too short");
    a_sync_held_high: assert property (frame_sync_in)
        else $error("frame sync not held high");
endmodule : sfc_link_sva

// ---- testbench/sar_adc_serial_frame_control_test.sv ----
`timescale 1ns/10ps
module sar_adc_serial_frame_control_test;
    import sfc_pkg::*;
    logic        core_clk, rst_n, init_req, frame_req, word_ready;
    logic        busy, word_valid, pwr_down, converting, sampling;
    logic [13:0] ana_code;
    logic [15:0] word, exp_next;
    logic [15:0] exp_q[$];
    int          bad_count, n_checks, cycles, dummy;
    int          conv_len, conv_run, samp_len, samp_run;
    bit          ready_free;

    sfc_link_if link_inst ();

    sfc_host #(.MODE(SFC_MODE_CS)) sfc_host_inst (
        .core_clk_i   (core_clk),
        .rst_n_i      (rst_n),
        .link         (link_inst.host),
        .init_req_i   (init_req),
        .frame_req_i  (frame_req),
        .busy_o       (busy),
        .word_o       (word),
        .word_valid_o (word_valid),
        .word_ready_i (word_ready)
    );

    sfc_device #(.MODE(SFC_MODE_CS)) sfc_device_inst (
        .core_clk_i     (core_clk),
        .rst_n_i        (rst_n),
        .link           (link_inst.device),
        .analog_code_i  (ana_code),
        .analog_valid_i (1'b1),
        .analog_ready_o (),
        .powered_down_o (pwr_down),
        .converting_o   (converting),
        .sampling_o     (sampling)
    );

    sfc_link_sva sfc_link_sva_inst (
        .core_clk_i    (core_clk),
        .rst_n_i       (rst_n),
        .sclk          (link_inst.sclk),
        .cs_n          (link_inst.cs_n),
        .frame_sync_in (link_inst.frame_sync_in),
        .serial_out    (link_inst.serial_out),
        .serial_out_oe (link_inst.serial_out_oe)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    task automatic fail(input string msg);
        bad_count++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask : fail

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
            fail($sformatf("got %h expected %h", got, exp));
    endtask : check

    task automatic check_range(input int v, input int lo, input int hi);
        n_checks++;
        if (v < lo || v > hi)
            fail($sformatf("%0d outside %0d..%0d", v, lo, hi));
    endtask : check_range

    // bounded wait so a stuck handshake cannot hang the run
    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy !== lvl && n < 3000)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (busy !== lvl)
            fail("busy wait expired");
    endtask : wait_busy

    task automatic do_init;
        init_req = 1'b1;
        wait_busy(1'b1);
        init_req = 1'b0;
        wait_busy(1'b0);
        exp_next = MARKER_WORD;
    endtask : do_init

    // code is held for the whole frame; its result shows one frame later
    task automatic run_frame(input logic [13:0] code, input bit wait_req);
        conv_len = 0;
        samp_len = 0;
        ana_code = code;
        exp_q.push_back(exp_next);
        exp_next = {code, 2'b00};
        frame_req = 1'b1;
        if (wait_req)
            wait_busy(1'b1);
        frame_req = 1'b0;
        wait_busy(1'b0);
        check_range(conv_len, CONV_CYCLES - 3, CONV_CYCLES + 3);
        check_range(conv_len, 1, CONV_MAX_CYC);
        check_range(samp_len, 154, 166);
        check({15'h0000, pwr_down}, 16'h0001);
        check({15'h0000, converting}, 16'h0000);
    endtask : run_frame

    // run lengths of the sampling and converting levels
    always @(posedge core_clk)
    begin
        if (converting === 1'b1)
            conv_run++;
        else if (conv_run != 0)
        begin
            conv_len = conv_run;
            conv_run = 0;
        end
        if (sampling === 1'b1)
            samp_run++;
        else if (samp_run != 0)
        begin
            samp_len = samp_run;
            samp_run = 0;
        end
    end

    // receiver stalls at random while free, else holds off
    always @(posedge core_clk)
    begin
        #1;
        word_ready = ready_free ? 1'($urandom_range(0, 1)) : 1'b0;
    end

    // oldest note is compared with each word taken from the buffer
    always @(posedge core_clk)
    begin
        if (rst_n && word_valid === 1'b1 && word_ready === 1'b1)
        begin
            if (exp_q.size() == 0)
                fail("word with no expectation");
            else
                check(word, exp_q.pop_front());
        end
    end

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            fail("run timed out");
            end_of_test();
        end
    end

    initial
    begin
        logic [13:0] codes[6];
        {init_req, frame_req, ready_free} = '0;
        ana_code = 14'h0000;
        exp_next = MARKER_WORD;
        rst_n = 1'b0;
        dummy = $urandom(82602);
        codes = '{14'h0000, 14'h3fff, 14'h1555, 14'h2aaa, 14'h0000, 14'h0000};
        codes[4] = 14'($urandom);
        codes[5] = 14'($urandom);
        repeat (8) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        @(posedge core_clk);
        #1;
        ready_free = 1'b1;
        do_init();
        foreach (codes[i])
            run_frame(codes[i], 1'b1);
        $display("test boundary_codes done");
        do_init();
        run_frame(14'($urandom), 1'b1);
        run_frame(14'($urandom), 1'b1);
        $display("test reinit done");
        ready_free = 1'b0;
        repeat (40) @(posedge core_clk);
        #1;
        run_frame(14'($urandom), 1'b1);
        run_frame(14'($urandom), 1'b1);
        exp_q.push_back(exp_next);
        frame_req = 1'b1;
        repeat (300)
        begin
            @(posedge core_clk);
            #1;
            check({15'h0000, busy}, 16'h0000); // full buffer refuses
        end
        check({15'h0000, word_valid}, 16'h0001);
        void'(exp_q.pop_back());
        frame_req = 1'b0;
        ready_free = 1'b1;
        run_frame(14'h0a5a, 1'b1);
        repeat (200) @(posedge core_clk);
        check_range(exp_q.size(), 0, 0);
        $display("test buffer_stall done");
        end_of_test();
    end
endmodule : sar_adc_serial_frame_control_test
